// ==== design/rbm_pkg.sv ====
// Functional notes
// - reset taken after two oscillator periods high
// - strobes pulled high within 5 us
// - strobes start after 2^17+512 periods
// - access select ignored in programming modes
// - clock may come from external oscillator source
package rbm_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RST_MIN_PERIODS = 2;
  localparam int unsigned PULL_HIGH_MAX_US = 5;
  localparam int unsigned PULL_HIGH_MAX_CYC = PULL_HIGH_MAX_US * CLK_MHZ;
  localparam int unsigned START_DELAY_CYC = (1 << 17) + 512;
  // ==========================================
  // mode-select pin codes {prog_n, serial_sel}
  localparam logic [1:0] MODE_PIN_PARALLEL = 2'h0;
  localparam logic [1:0] MODE_PIN_SERIAL = 2'h1;
  // ==========================================
  // boot modes
  typedef enum logic [1:0] {
    RBM_USER = 2'b00,
    RBM_PARALLEL = 2'b01,
    RBM_SERIAL = 2'b10
  } rbm_mode_t;
  // sequencer states
  typedef enum logic [1:0] {
    RBM_RUN = 2'b00,
    RBM_HELD = 2'b01,
    RBM_WAIT = 2'b10
  } rbm_state_t;
  // status bundle
  typedef struct packed {
    rbm_mode_t mode;
    logic ext_access;
    logic running;
  } rbm_status_t;
endpackage : rbm_pkg

// ==== design/rbm_reset_and_boot_mode_entry.sv ====
`timescale 1ns/1ps
// ==========================================
// reset and boot mode entry sequencer
// watches the reset pin, holds the strobes pulled high while the part is in
// reset, latches the boot mode at release and waits the start interval
// before the strobe pads are driven again
module rbm_reset_and_boot_mode_entry
  import rbm_pkg::*;
#(
  parameter int unsigned START_DELAY = START_DELAY_CYC, // release-to-start cycles
  parameter int unsigned RST_MIN = RST_MIN_PERIODS // periods reset must be high
) (
  input wire logic clock, // oscillator-derived clock
  input wire logic rst, // async power-on reset
  input wire logic clk_en, // freezes all state when low
  input wire logic reset_pin, // reset pin level, active high
  input wire logic [1:0] mode_pins, // {prog_n, serial_sel}
  input wire logic external_access_select, // external access pin
  output logic program_store_strobe_oe_n, // low while strobe pad driven
  output logic addr_latch_strobe_oe_n, // low while strobe pad driven
  output logic pull_high, // internal pull-up on both strobes
  output logic core_reset, // core held in reset
  output rbm_status_t status // latched mode and run flag
);
  // ==========================================
  // elaboration checks
  // a count of zero would leave the sequencer with nothing to wait for
  if (RST_MIN < 1 || START_DELAY < 1) begin : g_bad_count
    $error("rbm: counts must be at least one");
  end

  // ==========================================
  // sizes
  // the one counter serves both the high-time and the start interval
  localparam int unsigned CNT_TOP = (START_DELAY > RST_MIN) ? START_DELAY : RST_MIN;
  // one spare bit keeps the compare free of wrap-around
  localparam int unsigned CW = $clog2(CNT_TOP + 1) + 1; // counter width
  // program-store strobe and address-latch strobe
  localparam int unsigned N_STROBE = 2; // strobe pads handled alike

  // ==========================================
  // decoding helpers
  // decode pins into boot mode
  function automatic rbm_mode_t decode_mode(input logic [1:0] p);
    case (p)
      MODE_PIN_PARALLEL: decode_mode = RBM_PARALLEL; // programming, parallel
      MODE_PIN_SERIAL: decode_mode = RBM_SERIAL; // programming, serial
      default: decode_mode = RBM_USER; // user application
    endcase
  endfunction : decode_mode

  // access select counts only in user mode
  function automatic logic access_for(input rbm_mode_t m, input logic pin);
    access_for = (m == RBM_USER) ? pin : 1'b0;
  endfunction : access_for

  // ==========================================
  // sequencer state
  rbm_state_t state_r, state_nxt; // sequencer state
  logic [CW-1:0] cnt_r, cnt_nxt; // high-time / wait counter
  logic latch_now; // release seen this cycle

  // next-state logic of the sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    latch_now = 1'b0;
    case (state_r)
      RBM_RUN: begin
        // count high periods of the reset pin
        if (reset_pin) begin
          cnt_nxt = cnt_r + CW'(1);
          // enough high periods: take the reset
          if (cnt_r + CW'(1) >= CW'(RST_MIN)) begin
            state_nxt = RBM_HELD;
          end
        end else begin
          // a short pulse leaves no trace
          cnt_nxt = '0;
        end
      end
      RBM_HELD: begin
        // on release catch mode levels, they are stable from here
        if (!reset_pin) begin
          latch_now = 1'b1;
          cnt_nxt = '0;
          state_nxt = RBM_WAIT;
        end
      end
      RBM_WAIT: begin
        // counted interval, mode pins held by board
        if (reset_pin) begin
          // reset back before start: hold again
          cnt_nxt = '0;
          state_nxt = RBM_HELD;
        end else if (cnt_r >= CW'(START_DELAY - 1)) begin
          // interval used up: strobes may run
          cnt_nxt = '0;
          state_nxt = RBM_RUN;
        end else begin
          // keep counting
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        // unknown code: fall back to the safe held state
        state_nxt = RBM_HELD;
        cnt_nxt = '0;
      end
    endcase
  end

  // sequencer registers; clock may come from crystal or external source
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= RBM_HELD;
      cnt_r <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================
  // boot mode latch
  rbm_mode_t mode_r, mode_nxt; // latched boot mode
  logic acc_r, acc_nxt; // latched access select

  // mode levels taken once, at release
  always_comb begin
    mode_nxt = mode_r;
    acc_nxt = acc_r;
    if (latch_now) begin
      mode_nxt = decode_mode(mode_pins);
      // programming modes ignore access select
      acc_nxt = access_for(decode_mode(mode_pins), external_access_select);
    end
  end

  // mode registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= RBM_USER;
      acc_r <= 1'b0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      acc_r <= acc_nxt;
    end
  end

  // ==========================================
  // output flops
  logic pull_r, pull_nxt; // strobe pull-high
  logic core_r, core_nxt; // core reset
  logic [N_STROBE-1:0] oe_n_r, oe_n_nxt; // strobe pad enables, low = driven
  rbm_status_t status_r, status_nxt; // registered status bundle

  // outputs follow next state; pull high at the edge that takes reset
  always_comb begin
    pull_nxt = (state_nxt != RBM_RUN);
    core_nxt = (state_nxt != RBM_RUN);
    // pads stay undriven until the interval is over
    oe_n_nxt = {N_STROBE{state_nxt != RBM_RUN}};
    status_nxt = '{mode: mode_nxt, ext_access: acc_nxt, running: (state_nxt == RBM_RUN)};
  end

  // shared output registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pull_r <= 1'b1;
      core_r <= 1'b1;
      status_r <= '{mode: RBM_USER, ext_access: 1'b0, running: 1'b0};
    end else if (clk_en) begin
      pull_r <= pull_nxt;
      core_r <= core_nxt;
      status_r <= status_nxt;
    end
  end

  // one enable flop per strobe pad
  for (genvar g = 0; g < N_STROBE; g++) begin : g_strobe
    // pad released in reset so the pull-up wins
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        oe_n_r[g] <= 1'b1;
      end else if (clk_en) begin
        oe_n_r[g] <= oe_n_nxt[g];
      end
    end
  end

  // ==========================================
  // outputs straight from flops
  assign program_store_strobe_oe_n = oe_n_r[0]; // pad 0
  assign addr_latch_strobe_oe_n = oe_n_r[1]; // pad 1
  assign pull_high = pull_r;
  assign core_reset = core_r;
  assign status = status_r;
endmodule : rbm_reset_and_boot_mode_entry

// ==== verif/rbm_board_model.sv ====
`timescale 1ns/1ps
// =====
// board model
module rbm_board_model (
  input wire logic clock, // clock
  output logic reset_pin = 1'h1, // held at power-up
  output logic [1:0] mode_pins = 2'h2, // user
  output logic external_access_select = 1'h0 // access select
);
  // modes set while reset high, kept until next boot
  task automatic boot(input logic [1:0] m, input int hi);
    @(posedge clock) #1;
    reset_pin = 1'h1;
    mode_pins = m;
    external_access_select = 1'h1;
    repeat (hi) @(posedge clock);
    #1 reset_pin = 1'h0;
  endtask : boot
endmodule : rbm_board_model

// ==== verif/rbm_checker_sva.sv ====
`timescale 1ns/1ps
// =====
// boot checks
module rbm_checker
  import rbm_pkg::*;
#(parameter int START_DELAY = 16) (
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire logic clk_en, // state advance enable
  input wire logic reset_pin, // pin
  input wire logic [1:0] mode_pins, // modes
  input wire logic external_access_select, // access select
  input wire logic program_store_strobe_oe_n, // oe
  input wire logic addr_latch_strobe_oe_n, // oe
  input wire logic pull_high, // pull
  input wire logic core_reset, // core
  input wire rbm_status_t status // status
);
  localparam int REST = START_DELAY - 8; // rest of wait after the release window
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence hi2_s; reset_pin ##1 reset_pin; endsequence
  sequence rel_s; $fell(reset_pin) && pull_high && clk_en ##1 !reset_pin [*8]; endsequence
  entry_pull_a: assert property (hi2_s |=> pull_high && core_reset)
    else $error("entry");
  short_pulse_a: assert property (status.running && !reset_pin ##1 reset_pin ##1
    !reset_pin |=> status.running) else $error("pulse");
  start_delay_a: assert property (rel_s |-> ##REST pull_high ##1 !pull_high
    && !program_store_strobe_oe_n && status.running) else $error("delay");
  mode_latch_a: assert property ($rose(status.running) |-> status.mode ==
    (mode_pins[1] ? RBM_USER : mode_pins[0] ? RBM_SERIAL : RBM_PARALLEL)
    && status.ext_access == (mode_pins[1] && external_access_select)) else $error("mode");
  freeze_hold_a: assert property (!clk_en |=> $stable(status) && $stable(pull_high)
    && $stable(core_reset)) else $error("freeze");
  strobe_excl_a: assert property (program_store_strobe_oe_n == pull_high
    && addr_latch_strobe_oe_n == pull_high && core_reset == pull_high) else $error("excl");
endmodule : rbm_checker
bind rbm_reset_and_boot_mode_entry rbm_checker #(.START_DELAY(START_DELAY)) u_rbm_checker (.*);

// ==== verif/rbm_reset_and_boot_mode_entry_tb_top.sv ====
`timescale 1ns/1ps
// =====
// bench top
module rbm_reset_and_boot_mode_entry_tb_top;
  import rbm_pkg::*;
  logic clock = 1'h0, rst = 1'h1, clk_en = 1'h1, reset_pin, external_access_select; // pins
  logic [1:0] mode_pins; // modes
  logic program_store_strobe_oe_n, addr_latch_strobe_oe_n, pull_high, core_reset; // outs
  rbm_status_t status; // status
  int err_total = 0, comparisons = 0; // counts
  localparam int SD = 16; // start interval used in this bench
  rbm_board_model u_rbm_board_model (.*);
  rbm_reset_and_boot_mode_entry #(.START_DELAY(SD)) u_rbm_reset_and_boot_mode_entry (.*);
  initial forever #2.5 clock = ~clock; // 200 MHz
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict(input int add);
    err_total += add;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // boot one mode, count cycles to run
  task automatic t_boot(input logic [1:0] m, input logic [3:0] exp);
    int i;
    u_rbm_board_model.boot(m, 3);
    chk({6'h0, pull_high, core_reset}, 8'h03);
    for (i = 0; i < 40 && status.running !== 1'h1; i++) @(posedge clock) #1;
    if (i == 40) give_verdict(1);
    chk(8'(i), 8'(SD + 1));
    chk({4'h0, status}, {4'h0, exp});
    chk({6'h0, program_store_strobe_oe_n, addr_latch_strobe_oe_n}, 8'h00);
    $display("boot test done");
  endtask : t_boot
  // frozen clock enable stretches the start interval
  task automatic t_freeze;
    int i;
    u_rbm_board_model.boot(2'h2, 3);
    clk_en = 1'h0;
    repeat (10) @(posedge clock) #1;
    chk({6'h0, pull_high, status.running}, 8'h02);
    clk_en = 1'h1;
    for (i = 0; i < 40 && status.running !== 1'h1; i++) @(posedge clock) #1;
    if (i == 40) give_verdict(1);
    chk(8'(i), 8'(SD + 1));
    $display("freeze test done");
  endtask : t_freeze
  // reset back during the interval restarts the hold
  task automatic t_restart;
    int i;
    u_rbm_board_model.boot(2'h0, 3);
    repeat (4) @(posedge clock) #1;
    chk({6'h0, pull_high, status.running}, 8'h02);
    u_rbm_board_model.boot(2'h2, 3);
    for (i = 0; i < 40 && status.running !== 1'h1; i++) @(posedge clock) #1;
    if (i == 40) give_verdict(1);
    chk(8'(i), 8'(SD + 1));
    chk({4'h0, status}, 8'h03);
    $display("restart test done");
  endtask : t_restart
  // one-cycle pulse must be ignored
  task automatic t_short;
    u_rbm_board_model.boot(mode_pins, 1);
    repeat (4) @(posedge clock) #1;
    chk({7'h0, status.running}, 8'h01);
    chk({7'h0, pull_high}, 8'h00);
    $display("pulse test done");
  endtask : t_short
  initial begin
    repeat (6) @(posedge clock) #1;
    rst = 1'h0;
    t_boot(2'h2, 4'h3);
    t_boot(2'h0, 4'h5);
    t_boot(2'h1, 4'h9);
    t_short();
    t_freeze();
    t_restart();
    give_verdict(0);
  end
endmodule : rbm_reset_and_boot_mode_entry_tb_top
